// *** xrx_diag_regs.sv ***
// Purpose: receive diagnostic counters and status behind the management port
// Assumes: all inputs synchronous to SYS_CLK_I
// Notes: read data registered, one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module xrx_diag_regs
    import xrx_pkg::*;
(
    input wire logic SYS_CLK_I,
    input wire logic ARST_N_I,
    input wire xrx_mgmt_req_type MGMT_REQ_I,
    output logic [15:0] MGMT_RDATA_O,
    output logic MGMT_RVALID_O,
    input wire logic ALIGNED_I,
    input wire xrx_column_type RX_COL_I,
    input wire logic [3:0] CODE_ERR_I,
    input wire xrx_sync_states_type SYNC_STATES_I,
    input wire logic [3:0] ALIGN_STATE_I,
    input wire logic COLLISION_I,
    output logic TERM_ERR_O
);
    logic term_err;
    logic [15:0] term_cnt;
    logic [15:0] code_cnt [LANES];
    logic clr_term;
    logic [3:0] clr_code;
    logic rd_status;
    logic coll_q;
    logic coll_d;
    logic [15:0] sync_word;
    logic [15:0] status_word;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic rvalid_q;

    xrx_term_check u_term (
        .clk_i(SYS_CLK_I),
        .arst_n_i(ARST_N_I),
        .col_i(RX_COL_I),
        .err_o(term_err)
    );

    // read side effects; only reads are decoded, writes reach nothing
    always_comb begin
        clr_term = MGMT_REQ_I.rd && (MGMT_REQ_I.addr == ADDR_LANE3_TERM_ERR);
        clr_code[0] = MGMT_REQ_I.rd && (MGMT_REQ_I.addr == ADDR_LANE0_CODE_ERR);
        clr_code[1] = MGMT_REQ_I.rd && (MGMT_REQ_I.addr == ADDR_LANE1_CODE_ERR);
        clr_code[2] = MGMT_REQ_I.rd && (MGMT_REQ_I.addr == ADDR_LANE2_CODE_ERR);
        clr_code[3] = MGMT_REQ_I.rd && (MGMT_REQ_I.addr == ADDR_LANE3_CODE_ERR);
        rd_status = MGMT_REQ_I.rd && (MGMT_REQ_I.addr == ADDR_DESKEW_STATUS);
    end

    xrx_sat_counter u_term_cnt (
        .clk_i(SYS_CLK_I),
        .arst_n_i(ARST_N_I),
        .inc_i(term_err),
        .aligned_i(ALIGNED_I),
        .clr_i(clr_term),
        .count_o(term_cnt)
    );

    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : g_code
            xrx_sat_counter u_code_cnt (
                .clk_i(SYS_CLK_I),
                .arst_n_i(ARST_N_I),
                .inc_i(CODE_ERR_I[g]),
                .aligned_i(ALIGNED_I),
                .clr_i(clr_code[g]),
                .count_o(code_cnt[g])
            );
        end
    endgenerate

    // collision latch, new collision beats the read clear
    always_comb begin
        coll_d = COLLISION_I || (coll_q && !rd_status);
    end

    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            coll_q <= 1'b0;
        end else begin
            coll_q <= coll_d;
        end
    end

    // status word assembly
    always_comb begin
        sync_word = STATUS_RESET;
        sync_word[SYNC_L0_LSB +: SYNC_W] = SYNC_STATES_I.lane0;
        sync_word[SYNC_L1_LSB +: SYNC_W] = SYNC_STATES_I.lane1;
        sync_word[SYNC_L2_LSB +: SYNC_W] = SYNC_STATES_I.lane2;
        sync_word[SYNC_L3_LSB +: SYNC_W] = SYNC_STATES_I.lane3;
        status_word = STATUS_RESET;
        status_word[ALIGN_STATE_LSB +: ALIGN_W] = ALIGN_STATE_I;
        status_word[COLLISION_BIT] = coll_q;
    end

    // read mux, unmapped addresses read zero
    always_comb begin
        case (MGMT_REQ_I.addr)
            ADDR_LANE3_TERM_ERR: rdata_d = term_cnt;
            ADDR_LANE0_CODE_ERR: rdata_d = code_cnt[0];
            ADDR_LANE1_CODE_ERR: rdata_d = code_cnt[1];
            ADDR_LANE2_CODE_ERR: rdata_d = code_cnt[2];
            ADDR_LANE3_CODE_ERR: rdata_d = code_cnt[3];
            ADDR_SYNC_STATES: rdata_d = sync_word;
            ADDR_DESKEW_STATUS: rdata_d = status_word;
            default: rdata_d = STATUS_RESET;
        endcase
    end

    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rdata_q <= STATUS_RESET;
        end else if (MGMT_REQ_I.rd) begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= MGMT_REQ_I.rd;
        end
    end

    assign MGMT_RDATA_O = rdata_q;
    assign MGMT_RVALID_O = rvalid_q;
    assign TERM_ERR_O = term_err;
endmodule
`default_nettype wire

// *** xrx_pkg.sv ***
// Purpose: shared constants and carrier types for the receive diagnostic registers
// Assumes: 16-bit management data, register addresses as printed
// Notes: counters reset to a non-zero value on purpose
package xrx_pkg;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned LANES = 4;
    localparam int unsigned SYNC_W = 3;
    localparam int unsigned ALIGN_W = 4;

    // register addresses
    localparam logic [15:0] ADDR_LANE3_TERM_ERR = 16'h800f;
    localparam logic [15:0] ADDR_LANE0_CODE_ERR = 16'h8010;
    localparam logic [15:0] ADDR_LANE1_CODE_ERR = 16'h8011;
    localparam logic [15:0] ADDR_LANE2_CODE_ERR = 16'h8012;
    localparam logic [15:0] ADDR_LANE3_CODE_ERR = 16'h8013;
    localparam logic [15:0] ADDR_SYNC_STATES = 16'h8014;
    localparam logic [15:0] ADDR_DESKEW_STATUS = 16'h8015;

    // reset values and counter constants
    localparam logic [15:0] CNT_RESET = 16'hfffd;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [15:0] CNT_ZERO = 16'h0000;

    // field positions
    localparam int unsigned SYNC_L0_LSB = 9;
    localparam int unsigned SYNC_L1_LSB = 6;
    localparam int unsigned SYNC_L2_LSB = 3;
    localparam int unsigned SYNC_L3_LSB = 0;
    localparam int unsigned ALIGN_STATE_LSB = 12;
    localparam int unsigned COLLISION_BIT = 0;

    // one received column as seen by the termination checker
    typedef struct packed {
        logic valid;
        logic term_lane3;
        logic is_k_col;
        logic is_a_col;
    } xrx_column_type;

    // management read request
    typedef struct packed {
        logic rd;
        logic [15:0] addr;
    } xrx_mgmt_req_type;

    // receive datapath state to report
    typedef struct packed {
        logic [2:0] lane0;
        logic [2:0] lane1;
        logic [2:0] lane2;
        logic [2:0] lane3;
    } xrx_sync_states_type;
endpackage

// *** xrx_sat_counter.sv ***
// Purpose: 16-bit saturating error counter, cleared by a read
// Assumes: clear and increment may coincide
// Notes: an event in the clearing cycle is kept as a count of one
`timescale 1ns/1ps
`default_nettype none
module xrx_sat_counter
    import xrx_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic inc_i,
    input wire logic aligned_i,
    input wire logic clr_i,
    output logic [15:0] count_o
);
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [15:0] base;

    always_comb begin
        base = clr_i ? CNT_ZERO : cnt_q;
        cnt_d = base;
        if (inc_i && aligned_i && (base != CNT_MAX)) begin
            cnt_d = base + CNT_ONE;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q <= CNT_RESET;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign count_o = cnt_q;
endmodule
`default_nettype wire

// *** xrx_term_check.sv ***
// Purpose: lane 3 terminate follow-up check
// Assumes: one column per valid cycle
// Notes: error pulse comes with the column after the terminate
`timescale 1ns/1ps
`default_nettype none
module xrx_term_check
    import xrx_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire xrx_column_type col_i,
    output logic err_o
);
    logic pend_q;

    // remember a terminate in lane 3 until the next column
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pend_q <= 1'b0;
        end else if (col_i.valid) begin
            pend_q <= col_i.term_lane3;
        end
    end

    assign err_o = col_i.valid && pend_q && !(col_i.is_k_col || col_i.is_a_col);
endmodule
`default_nettype wire

// *** xrx_diag_regs_checker.sv ***
// Purpose: port checks for the receive diagnostic registers
// Assumes: read data one cycle after the strobe
// Notes: bound from the bench
`timescale 1ns/1ps
`default_nettype none
module xrx_diag_regs_checker
    import xrx_pkg::*;
(
    input wire logic SYS_CLK_I,
    input wire logic ARST_N_I,
    input wire xrx_mgmt_req_type MGMT_REQ_I,
    input wire logic [15:0] MGMT_RDATA_O,
    input wire logic MGMT_RVALID_O,
    input wire logic ALIGNED_I,
    input wire xrx_column_type RX_COL_I,
    input wire logic [3:0] CODE_ERR_I,
    input wire xrx_sync_states_type SYNC_STATES_I,
    input wire logic [3:0] ALIGN_STATE_I,
    input wire logic COLLISION_I,
    input wire logic TERM_ERR_O
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!ARST_N_I);
    wire logic rd = MGMT_REQ_I.rd;
    wire logic st = rd && MGMT_REQ_I.addr == ADDR_DESKEW_STATUS;
    wire logic c0 = rd && MGMT_REQ_I.addr == ADDR_LANE0_CODE_ERR;
    wire logic c3 = rd && MGMT_REQ_I.addr == ADDR_LANE3_CODE_ERR;
    wire logic bad = RX_COL_I.valid && !RX_COL_I.is_k_col && !RX_COL_I.is_a_col;
    read_answer_a: assert property (rd |=> MGMT_RVALID_O) else $error("read not answered");
    no_answer_a: assert property (!rd |=> !MGMT_RVALID_O) else $error("answer without read");
    term_cause_a: assert property (TERM_ERR_O |-> bad) else $error("termination flag without cause");
    term_seen_a: assert property (RX_COL_I.valid && RX_COL_I.term_lane3 ##1 bad |-> TERM_ERR_O)
        else $error("termination error missed");
    sync_field_a: assert property (rd && MGMT_REQ_I.addr == ADDR_SYNC_STATES
        |=> MGMT_RDATA_O == {4'h0, $past(SYNC_STATES_I)}) else $error("sync states wrong");
    align_field_a: assert property (st |=> MGMT_RDATA_O[15:12] == $past(ALIGN_STATE_I))
        else $error("align state wrong");
    collision_latch_a: assert property (COLLISION_I ##1 st |=> MGMT_RDATA_O[0]) else $error("collision lost");
    collision_clear_a: assert property (st && !COLLISION_I ##1 st |=> !MGMT_RDATA_O[0])
        else $error("collision not cleared");
    read_clear_a: assert property (c0 ##1 c0 |=> MGMT_RDATA_O <= CNT_ONE) else $error("counter not cleared");
    hold_idle_a: assert property (c3 && !ALIGNED_I ##1 c3 |=> MGMT_RDATA_O == CNT_ZERO)
        else $error("counter moved unaligned");
    cover property (TERM_ERR_O && ALIGNED_I);
    cover property (COLLISION_I ##1 st);
    cover property (c0 ##1 c0);
endmodule
`default_nettype wire

// *** xrx_diag_regs_bench.sv ***
// Purpose: self-checking bench for the receive diagnostic registers
// Assumes: read data one cycle after the strobe
// Notes: every read is done twice, back to back
`timescale 1ns/1ps
`default_nettype none
module xrx_diag_regs_bench
    import xrx_pkg::*;
;
    logic clk = 0, rst_n = 0, al = 0, coll = 0, rv, term;
    xrx_mgmt_req_type req = '0;
    xrx_column_type col = '0;
    xrx_sync_states_type sy = '0;
    logic [3:0] ce = '0, ast = '0;
    logic [15:0] rdata, e;
    logic [15:0] exp_q[$];
    logic [15:0] ad[5] = '{ADDR_LANE3_TERM_ERR, ADDR_LANE0_CODE_ERR, ADDR_LANE1_CODE_ERR,
        ADDR_LANE2_CODE_ERR, ADDR_LANE3_CODE_ERR};
    logic [31:0] r;
    int cnt[5];
    int failures = 0, n_compared = 0;
    initial begin
        forever #5 clk = ~clk;
    end
    xrx_diag_regs u_xrx_diag_regs(.SYS_CLK_I(clk), .ARST_N_I(rst_n), .MGMT_REQ_I(req), .MGMT_RDATA_O(rdata),
        .MGMT_RVALID_O(rv), .ALIGNED_I(al), .RX_COL_I(col), .CODE_ERR_I(ce), .SYNC_STATES_I(sy),
        .ALIGN_STATE_I(ast), .COLLISION_I(coll), .TERM_ERR_O(term));
    task automatic stop_test;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // answer watcher
    always @(posedge clk) begin
        if (rv === 1'b1) begin
            n_compared++;
            e = exp_q.size() ? exp_q.pop_front() : 'x;
            if (rdata !== e) begin
                failures++;
                $display("unexpected read data expected %h seen %h", e, rdata);
            end
        end
    end
    task automatic rd(input logic [15:0] a, e1, e2);
        @(posedge clk);
        req <= '{1'b1, a};
        exp_q.push_back(e1);
        @(posedge clk);
        exp_q.push_back(e2);
        @(posedge clk);
        req.rd <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic ev(input logic [3:0] m, input logic t, k, a);
        @(posedge clk);
        ce <= m;
        col <= {1'b1, t, 2'b00};
        @(posedge clk);
        ce <= '0;
        col <= {2'b10, k, a};
        @(posedge clk);
        col <= '0;
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        failures++;
        stop_test;
    end
    initial begin
        r = $urandom(3051);
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        al <= 1'b1;
        repeat (4) ev(4'hf, 1'b1, 1'b0, 1'b0);
        foreach (ad[i]) rd(ad[i], CNT_MAX, CNT_ZERO);
        $display("test saturation done");
        repeat (2) ev(4'hf, 1'b1, 1'b0, 1'b0);
        al <= 1'b0;
        repeat (3) ev(4'hf, 1'b1, 1'b0, 1'b0);
        foreach (ad[i]) rd(ad[i], 16'h0002, CNT_ZERO);
        $display("test hold done");
        al <= 1'b1;
        cnt = '{default: 0};
        repeat (40) begin
            r = $urandom;
            ev(r[3:0], r[4], r[5], r[6]);
            cnt[0] += r[4] && !r[5] && !r[6];
            for (int i = 0; i < 4; i++) cnt[i + 1] += r[i];
        end
        foreach (ad[i]) rd(ad[i], 16'(cnt[i]), CNT_ZERO);
        $display("test counting done");
        for (int j = 0; j < 4; j++) begin
            r = $urandom;
            sy <= r[11:0];
            ast <= r[15:12];
            rd(ADDR_SYNC_STATES, {4'h0, r[11:0]}, {4'h0, r[11:0]});
            rd(ADDR_DESKEW_STATUS, {r[15:12], 12'h000}, {r[15:12], 12'h000});
        end
        $display("test status fields done");
        @(posedge clk);
        coll <= 1'b1;
        fork
            rd(ADDR_DESKEW_STATUS, {ast, 12'h001}, {ast, 12'h000});
            begin
                @(posedge clk);
                coll <= 1'b0;
            end
        join
        coll <= 1'b1;
        rd(ADDR_DESKEW_STATUS, {ast, 12'h001}, {ast, 12'h001});
        coll <= 1'b0;
        rd(16'h8016, CNT_ZERO, CNT_ZERO);
        $display("test collision done");
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        foreach (ad[i]) rd(ad[i], CNT_RESET, CNT_ZERO);
        rd(ADDR_DESKEW_STATUS, {ast, 12'h000}, {ast, 12'h000});
        $display("test reset done");
        repeat (3) @(posedge clk);
        stop_test;
    end
endmodule
bind xrx_diag_regs xrx_diag_regs_checker u_xrx_diag_regs_checker(.SYS_CLK_I(SYS_CLK_I), .ARST_N_I(ARST_N_I),
    .MGMT_REQ_I(MGMT_REQ_I), .MGMT_RDATA_O(MGMT_RDATA_O), .MGMT_RVALID_O(MGMT_RVALID_O), .ALIGNED_I(ALIGNED_I),
    .RX_COL_I(RX_COL_I), .CODE_ERR_I(CODE_ERR_I), .SYNC_STATES_I(SYNC_STATES_I), .ALIGN_STATE_I(ALIGN_STATE_I),
    .COLLISION_I(COLLISION_I), .TERM_ERR_O(TERM_ERR_O));
`default_nettype wire
